// [core/acmi_params.svh]
`ifndef ACMI_PARAMS_SVH
`define ACMI_PARAMS_SVH

`define ACMI_ADDR_W        6
`define ACMI_OFS_CONTROL   6'h0C
`define ACMI_OFS_CMP_A     6'h10
`define ACMI_OFS_CMP_B     6'h14
`define ACMI_OFS_VSEL      6'h20
`define ACMI_OFS_STATUS    6'h24
`define ACMI_OFS_MASK      6'h28
`define ACMI_OFS_ERRCTL    6'h2C

`define ACMI_CLR_LSB       24
`define ACMI_CLR_MSB       26
`define ACMI_IRS_BIT       16
`define ACMI_FLAG_MSB      2
`define ACMI_LOCK_BIT      0
`define ACMI_CMP_HI_LSB    16
`define ACMI_CMP_HI_MSB    31
`define ACMI_CMP_LO_MSB    15
`define ACMI_CLR_LANE      3
`define ACMI_IRS_LANE      2
`define ACMI_LOW_LANE      0
`define ACMI_CONTROL_USED  32'h07010007
`define ACMI_CMP_B_USED    32'h0000FFFF
`define ACMI_LOW3_USED     32'h00000007
`define ACMI_LOW1_USED     32'h00000001

`define ACMI_RST_WORD      32'h00000000
`define ACMI_RST_HALF      16'h0000
`define ACMI_RST_TRIPLE    3'h0

`define ACMI_RES_13        5'h0D
`define ACMI_RES_12        5'h0C
`define ACMI_RES_11        5'h0B
`define ACMI_RES_10        5'h0A
`define ACMI_RES_16        5'h10
`define ACMI_RES_14        5'h0E
`define ACMI_VEL_120K      20'h1D4C0
`define ACMI_VEL_240K      20'h3A980
`define ACMI_VEL_480K      20'h75300
`define ACMI_VEL_960K      20'hEA600
`define ACMI_VEL_15K       20'h03A98
`define ACMI_VEL_60K       20'h0EA60

`endif

// [core/acmi_pkg.sv]
`include "acmi_params.svh"

package acmi_pkg;

    typedef logic [2:0][15:0] acmi_cmp_t;

    typedef enum logic {
        ACMI_BUS_IDLE,
        ACMI_BUS_ACK
    } acmi_bus_state_t;

    typedef struct packed {
        logic                    read;
        logic                    write;
        logic [`ACMI_ADDR_W-1:0] address;
        logic [31:0]             writedata;
        logic [3:0]              byteenable;
    } acmi_avs_req_t;

    typedef struct packed {
        acmi_bus_state_t bus;
        logic [31:0]     rdata;
        logic [15:0]     angle_compare_value_0;
        logic [15:0]     angle_compare_value_1;
        logic [15:0]     angle_compare_value_2;
        logic            request_source_select;
        logic [2:0]      clr;
        logic [2:0]      flag;
        logic [2:0]      pulse;
        logic [2:0]      stat;
        logic [2:0]      mask;
        logic [2:0]      vsel;
        logic            lock;
    } acmi_state_t;

endpackage

// [core/acmi_match_detect.sv]
`include "acmi_params.svh"

module acmi_match_detect (
    input  wire logic              [15:0] phi_angle,
    input  wire logic                     phi_valid,
    input  wire acmi_pkg::acmi_cmp_t      cmp,
    output logic                   [2:0]  match
);
    import acmi_pkg::*;

    // One comparator per compare value; a match only counts on a fresh angle sample.
    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_cmp
            assign match[i] = phi_valid && (phi_angle == cmp[i]);
        end
    endgenerate
endmodule

// [core/acmi_resolution_decode.sv]
`include "acmi_params.svh"

module acmi_resolution_decode (
    input  wire logic [2:0]  max_velocity_select,
    output logic      [4:0]  resolution_bits,
    output logic      [19:0] max_velocity_rpm
);
    import acmi_pkg::*;

    function automatic logic [24:0] acmi_decode(input logic [2:0] code);
        case (code)
            3'h0:    acmi_decode = {`ACMI_RES_13, `ACMI_VEL_120K};
            3'h1:    acmi_decode = {`ACMI_RES_12, `ACMI_VEL_240K};
            3'h2:    acmi_decode = {`ACMI_RES_11, `ACMI_VEL_480K};
            3'h3:    acmi_decode = {`ACMI_RES_10, `ACMI_VEL_960K};
            3'h4:    acmi_decode = {`ACMI_RES_16, `ACMI_VEL_15K};
            3'h5:    acmi_decode = {`ACMI_RES_14, `ACMI_VEL_60K};
            default: acmi_decode = {`ACMI_RES_12, `ACMI_VEL_240K};
        endcase
    endfunction

    // Velocity figures are those for a 40 MHz converter clock.
    assign {resolution_bits, max_velocity_rpm} = acmi_decode(max_velocity_select);
endmodule

// [core/acmi_top.sv]
// Operation
// - Velocity select code sets conversion resolution.
// - Code sets maximum angular velocity at 40 MHz.
// - Writing one to clear bit clears flag.
// - Clear bit returns to zero by itself.
// - Select bit picks raw or latched request.
// - Flag reads one once request generated.
// - Error lock freezes flags during an error.
// - Clear bits work even under error lock.
// - Three independent sixteen bit compare values.
// - Reserved bits always read zero.
// - Byte, half and word access with lanes.
// - All compare registers reset to zero.
//
// The Avalon-MM slave port is this design's own decision.
`include "acmi_params.svh"

module acmi_top (
    input  wire logic                    core_clk,
    input  wire logic                    srst,
    input  wire acmi_pkg::acmi_avs_req_t avs_req,
    output logic                  [31:0] avs_readdata,
    output logic                         avs_waitrequest,
    input  wire logic             [15:0] phi_angle,
    input  wire logic                    phi_valid,
    input  wire logic                    phi_error,
    output logic                  [2:0]  irq_match,
    output logic                         irq,
    output logic                  [4:0]  resolution_bits,
    output logic                  [19:0] max_velocity_rpm
);
    import acmi_pkg::*;

    acmi_state_t st;
    acmi_state_t next_st;
    logic [2:0]  match_evt;
    logic        blocked;
    logic        access;
    logic        wr_acc;
    logic        rd_acc;
    logic [2:0]  stat_clr;

    function automatic logic [31:0] acmi_merge(input logic [31:0] old_word,
                                               input logic [31:0] new_word,
                                               input logic [3:0]  lanes);
        logic [31:0] res;
        res = old_word;
        for (int b = 0; b < 4; b++) begin
            if (lanes[b]) begin
                res[b*8 +: 8] = new_word[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [31:0] acmi_read_word(input acmi_state_t s,
                                                   input logic [`ACMI_ADDR_W-1:0] a);
        case (a)
            `ACMI_OFS_CONTROL: acmi_read_word = {5'h00, s.clr, 7'h00, s.request_source_select, 13'h0000, s.flag};
            `ACMI_OFS_CMP_A:   acmi_read_word = {s.angle_compare_value_1, s.angle_compare_value_0};
            `ACMI_OFS_CMP_B:   acmi_read_word = {16'h0000, s.angle_compare_value_2};
            `ACMI_OFS_VSEL:    acmi_read_word = {29'h00000000, s.vsel};
            `ACMI_OFS_STATUS:  acmi_read_word = {29'h00000000, s.stat};
            `ACMI_OFS_MASK:    acmi_read_word = {29'h00000000, s.mask};
            `ACMI_OFS_ERRCTL:  acmi_read_word = {31'h00000000, s.lock};
            default:           acmi_read_word = `ACMI_RST_WORD;
        endcase
    endfunction

    acmi_match_detect u_match (
        .phi_angle (phi_angle),
        .phi_valid (phi_valid),
        .cmp       ({st.angle_compare_value_2, st.angle_compare_value_1, st.angle_compare_value_0}),
        .match     (match_evt)
    );

    acmi_resolution_decode u_decode (
        .max_velocity_select (st.vsel),
        .resolution_bits     (resolution_bits),
        .max_velocity_rpm    (max_velocity_rpm)
    );

    // The bus answers every request after exactly one wait cycle.
    assign access          = avs_req.read || avs_req.write;
    assign wr_acc          = avs_req.write && (st.bus == ACMI_BUS_ACK);
    assign rd_acc          = avs_req.read && (st.bus == ACMI_BUS_ACK);
    assign avs_waitrequest = access && (st.bus != ACMI_BUS_ACK);
    assign avs_readdata    = st.rdata;
    assign blocked         = st.lock && phi_error;

    // Only status bits that the answered read actually returned are cleared.
    assign stat_clr = (rd_acc && (avs_req.address == `ACMI_OFS_STATUS)) ?
                      st.rdata[`ACMI_FLAG_MSB:0] : `ACMI_RST_TRIPLE;

    always_comb begin
        logic [31:0] merged;
        merged  = `ACMI_RST_WORD;
        next_st = st;
        case (st.bus)
            ACMI_BUS_IDLE: begin
                if (access) begin
                    next_st.bus   = ACMI_BUS_ACK;
                    next_st.rdata = acmi_read_word(st, avs_req.address);
                end
            end
            ACMI_BUS_ACK: begin
                next_st.bus = ACMI_BUS_IDLE;
            end
            default: begin
                next_st.bus = ACMI_BUS_IDLE;
            end
        endcase

        next_st.pulse = match_evt;
        next_st.clr   = `ACMI_RST_TRIPLE;
        // A new match wins over a clear landing in the same cycle, except under error lock, where the clear wins.
        next_st.flag  = (st.flag & ~st.clr) | (match_evt & ~{3{blocked}});
        next_st.stat  = (st.stat & ~stat_clr) | match_evt;

        if (wr_acc) begin
            case (avs_req.address)
                `ACMI_OFS_CONTROL: begin
                    if (avs_req.byteenable[`ACMI_CLR_LANE]) begin
                        next_st.clr = avs_req.writedata[`ACMI_CLR_MSB:`ACMI_CLR_LSB];
                    end
                    if (avs_req.byteenable[`ACMI_IRS_LANE]) begin
                        next_st.request_source_select = avs_req.writedata[`ACMI_IRS_BIT];
                    end
                end
                `ACMI_OFS_CMP_A: begin
                    merged = acmi_merge({st.angle_compare_value_1, st.angle_compare_value_0}, avs_req.writedata,
                                        avs_req.byteenable);
                    next_st.angle_compare_value_1 = merged[`ACMI_CMP_HI_MSB:`ACMI_CMP_HI_LSB];
                    next_st.angle_compare_value_0 = merged[`ACMI_CMP_LO_MSB:0];
                end
                `ACMI_OFS_CMP_B: begin
                    merged = acmi_merge({16'h0000, st.angle_compare_value_2}, avs_req.writedata,
                                        avs_req.byteenable);
                    next_st.angle_compare_value_2 = merged[`ACMI_CMP_LO_MSB:0];
                end
                `ACMI_OFS_VSEL: begin
                    if (avs_req.byteenable[`ACMI_LOW_LANE]) begin
                        next_st.vsel = avs_req.writedata[`ACMI_FLAG_MSB:0];
                    end
                end
                `ACMI_OFS_MASK: begin
                    if (avs_req.byteenable[`ACMI_LOW_LANE]) begin
                        next_st.mask = avs_req.writedata[`ACMI_FLAG_MSB:0];
                    end
                end
                `ACMI_OFS_ERRCTL: begin
                    if (avs_req.byteenable[`ACMI_LOW_LANE]) begin
                        next_st.lock = avs_req.writedata[`ACMI_LOCK_BIT];
                    end
                end
                default: begin
                    next_st.bus = ACMI_BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign irq_match = st.request_source_select ? st.flag : st.pulse;
    assign irq       = |(st.stat & st.mask);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    logic [31:0] used_bits;
    always_comb begin
        case (avs_req.address)
            `ACMI_OFS_CONTROL: used_bits = `ACMI_CONTROL_USED;
            `ACMI_OFS_CMP_A:   used_bits = ~`ACMI_RST_WORD;
            `ACMI_OFS_CMP_B:   used_bits = `ACMI_CMP_B_USED;
            `ACMI_OFS_ERRCTL:  used_bits = `ACMI_LOW1_USED;
            default:           used_bits = `ACMI_LOW3_USED;
        endcase
    end

    AST_CLR_SELF_RETURN: assert property (
        (|st.clr) |=> (st.clr == `ACMI_RST_TRIPLE)
    ) else $error("clear bit did not return to zero");

    AST_CLR_CLEARS_FLAG: assert property (
        (st.clr[0] && !match_evt[0]) |=> !st.flag[0] && (!st.request_source_select || !irq_match[0])
    ) else $error("clear bit did not clear flag 0");

    AST_CLR_UNDER_LOCK: assert property (
        (blocked && st.clr[2]) |=> !st.flag[2]
    ) else $error("clear under error lock failed");

    AST_MATCH_SETS_FLAG: assert property (
        (phi_valid && (phi_angle == st.angle_compare_value_2) && !blocked) |=> st.flag[2]
    ) else $error("match on value 2 did not set flag");

    AST_LOCK_FREEZES: assert property (
        (blocked && (st.clr == `ACMI_RST_TRIPLE)) |=> (st.flag == $past(st.flag))
    ) else $error("flags moved under error lock");

    AST_FLAG_STICKY: assert property (
        (st.flag[0] && !st.clr[0]) |=> st.flag[0]
    ) else $error("flag dropped without a clear");

    AST_RAW_SOURCE: assert property (
        (!st.request_source_select && !$past(srst)) |-> (irq_match == $past(match_evt))
    ) else $error("raw request source is not the registered match");

    AST_LATCH_SOURCE: assert property (
        (st.request_source_select && st.flag[0]) |-> irq_match[0]
    ) else $error("latched request source lost");

    AST_RES_DECODE: assert property (
        (st.vsel == 3'h4) |-> (resolution_bits == `ACMI_RES_16)
    ) else $error("code 4 does not give 16 bits");

    AST_VEL_DECODE: assert property (
        (st.vsel == 3'h3) |-> (max_velocity_rpm == `ACMI_VEL_960K)
    ) else $error("code 3 velocity wrong");

    AST_RESERVED_ZERO: assert property (
        (avs_req.read && !avs_waitrequest) |-> ((avs_readdata & ~used_bits) == `ACMI_RST_WORD)
    ) else $error("reserved bits read nonzero");

    AST_LANE_KEEP: assert property (
        (wr_acc && (avs_req.address == `ACMI_OFS_CMP_A) && (avs_req.byteenable == 4'h2))
        |=> (st.angle_compare_value_1 == $past(st.angle_compare_value_1)) && (st.angle_compare_value_0[7:0] == $past(st.angle_compare_value_0[7:0]))
    ) else $error("unselected byte lanes changed");

    AST_WORD_WRITE: assert property (
        (wr_acc && (avs_req.address == `ACMI_OFS_CMP_A) && (avs_req.byteenable == 4'hF))
        |=> (st.angle_compare_value_1 == $past(avs_req.writedata[31:16]))
    ) else $error("compare value 1 not written");

    AST_ONE_WAIT: assert property (
        avs_waitrequest |=> !avs_waitrequest
    ) else $error("bus answer took more than one wait cycle");

    AST_RESET_ZERO: assert property (
        $past(srst) |-> (st.angle_compare_value_0 == `ACMI_RST_HALF) && (st.flag == `ACMI_RST_TRIPLE) && !st.request_source_select
    ) else $error("state not zero after reset");

    AST_CLR_CLEARS_FLAG1: assert property (
        (st.clr[1] && !match_evt[1]) |=> !st.flag[1]
    ) else $error("clear bit did not clear flag 1");

    AST_CLR_CLEARS_FLAG2: assert property (
        (st.clr[2] && !match_evt[2]) |=> !st.flag[2]
    ) else $error("clear bit did not clear flag 2");

    AST_SET_WINS: assert property (
        (st.clr[0] && match_evt[0] && !blocked) |=> st.flag[0]
    ) else $error("match lost against a clear in the same cycle");

    // Field writes land at the edge that follows the answered request.
    AST_CLR_WRITE_ONE: assert property (
        (wr_acc && (avs_req.address == `ACMI_OFS_CONTROL) && avs_req.byteenable[`ACMI_CLR_LANE])
        |=> (st.clr == $past(avs_req.writedata[`ACMI_CLR_MSB:`ACMI_CLR_LSB]))
    ) else $error("clear bits not taken from the write");

    AST_CLR_WRITE_ZERO: assert property (
        (wr_acc && !avs_req.byteenable[`ACMI_CLR_LANE]) |=> (st.clr == `ACMI_RST_TRIPLE)
    ) else $error("clear bits set without a write to their lane");

    AST_IRS_WRITE: assert property (
        (wr_acc && (avs_req.address == `ACMI_OFS_CONTROL) && avs_req.byteenable[`ACMI_IRS_LANE])
        |=> (st.request_source_select == $past(avs_req.writedata[`ACMI_IRS_BIT]))
    ) else $error("request source select not written");

    AST_MATCH_SETS_FLAG0: assert property (
        (phi_valid && (phi_angle == st.angle_compare_value_0) && !blocked) |=> st.flag[0]
    ) else $error("match on value 0 did not set flag");

    AST_MATCH_SETS_FLAG1: assert property (
        (phi_valid && (phi_angle == st.angle_compare_value_1) && !blocked) |=> st.flag[1]
    ) else $error("match on value 1 did not set flag");

    AST_MASK_WRITE: assert property (
        (wr_acc && (avs_req.address == `ACMI_OFS_MASK) && avs_req.byteenable[`ACMI_LOW_LANE])
        |=> (st.mask == $past(avs_req.writedata[`ACMI_FLAG_MSB:0]))
    ) else $error("mask not written");

    AST_STATUS_SET: assert property (
        match_evt[0] |=> st.stat[0]
    ) else $error("match did not set status bit 0");

    AST_STATUS_READ_CLEAR: assert property (
        (rd_acc && (avs_req.address == `ACMI_OFS_STATUS) && st.rdata[0] && !match_evt[0])
        |=> !st.stat[0]
    ) else $error("status read did not clear bit 0");

    AST_STATUS_KEEP: assert property (
        (st.stat[1] && !rd_acc) |=> st.stat[1]
    ) else $error("status bit 1 dropped without a read");

    AST_RDATA_HOLD: assert property (
        (st.bus == ACMI_BUS_ACK) |=> $stable(avs_readdata)
    ) else $error("read data moved after the answer");

    AST_RDATA_IDLE: assert property (
        !access |=> $stable(avs_readdata)
    ) else $error("read data moved without a request");

    AST_READ_FLAGS: assert property (
        (rd_acc && (avs_req.address == `ACMI_OFS_CONTROL))
        |-> (avs_readdata[`ACMI_FLAG_MSB:0] == $past(st.flag))
    ) else $error("control read does not return the flags");

    AST_READ_CMP_A: assert property (
        (rd_acc && (avs_req.address == `ACMI_OFS_CMP_A))
        |-> (avs_readdata == {st.angle_compare_value_1, st.angle_compare_value_0})
    ) else $error("compare values 0 and 1 read wrong");

    AST_CMP_B_RESERVED: assert property (
        (rd_acc && (avs_req.address == `ACMI_OFS_CMP_B))
        |-> (avs_readdata[`ACMI_CMP_HI_MSB:`ACMI_CMP_HI_LSB] == `ACMI_RST_HALF)
    ) else $error("upper half of compare value 2 word not zero");

    AST_CMP_B_WRITE: assert property (
        (wr_acc && (avs_req.address == `ACMI_OFS_CMP_B) && (avs_req.byteenable == 4'h3))
        |=> (st.angle_compare_value_2 == $past(avs_req.writedata[`ACMI_CMP_LO_MSB:0]))
    ) else $error("compare value 2 not written");

    AST_VSEL_WRITE: assert property (
        (wr_acc && (avs_req.address == `ACMI_OFS_VSEL) && avs_req.byteenable[`ACMI_LOW_LANE])
        |=> (st.vsel == $past(avs_req.writedata[`ACMI_FLAG_MSB:0]))
    ) else $error("velocity select not written");

    AST_RES_SPARE: assert property (
        (st.vsel[2:1] == 2'h3)
        |-> (resolution_bits == `ACMI_RES_12) && (max_velocity_rpm == `ACMI_VEL_240K)
    ) else $error("spare codes do not give the default setting");

    AST_RES_CODE0: assert property (
        (st.vsel == 3'h0)
        |-> (resolution_bits == `ACMI_RES_13) && (max_velocity_rpm == `ACMI_VEL_120K)
    ) else $error("code 0 decode wrong");

    AST_LOCK_WRITE: assert property (
        (wr_acc && (avs_req.address == `ACMI_OFS_ERRCTL) && avs_req.byteenable[`ACMI_LOW_LANE])
        |=> (st.lock == $past(avs_req.writedata[`ACMI_LOCK_BIT]))
    ) else $error("error lock control not written");

    AST_RESET_REST: assert property (
        $past(srst) |-> (st.angle_compare_value_1 == `ACMI_RST_HALF) && (st.angle_compare_value_2 == `ACMI_RST_HALF)
        && (st.clr == `ACMI_RST_TRIPLE) && !irq
    ) else $error("compare state not zero after reset");

    COV_FLAG_SET:    cover property (!st.flag[0] ##1 st.flag[0]);
    COV_FLAG_CLEAR:  cover property (st.flag[1] ##1 st.clr[1] ##1 !st.flag[1]);
    COV_LATCHED_IRQ: cover property (st.request_source_select && irq_match[2]);
    COV_STATUS_READ: cover property (irq ##[1:20] (rd_acc && (avs_req.address == `ACMI_OFS_STATUS)));
    COV_LOCK_HOLD:   cover property (blocked && match_evt[2]);
endmodule

// [verif/acmi_irq_sink.sv]
module acmi_irq_sink (
    input  wire logic            core_clk,
    input  wire logic            srst,
    input  wire logic [2:0]      irq_match,
    input  wire logic            irq,
    output logic      [2:0][7:0] req_edges,
    output logic      [7:0]      irq_edges
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] prev;
    logic       irq_prev;
    // Counts each new request per index, as an edge-sensitive controller would.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            prev      <= 3'h0;
            irq_prev  <= 1'b0;
            req_edges <= '0;
            irq_edges <= 8'h00;
        end else begin
            prev     <= irq_match;
            irq_prev <= irq;
            for (int i = 0; i < 3; i++) begin
                if (irq_match[i] && !prev[i]) begin
                    req_edges[i] <= req_edges[i] + 8'h01;
                end
            end
            if (irq && !irq_prev) begin
                irq_edges <= irq_edges + 8'h01;
            end
        end
    end
endmodule

// [verif/acmi_top_tb.sv]
`include "acmi_params.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module acmi_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import acmi_pkg::*;
    logic                core_clk;
    logic                srst;
    acmi_avs_req_t       req;
    logic [31:0]         rdata;
    logic                wreq;
    logic [15:0]         phi_angle;
    logic                phi_valid;
    logic                phi_error;
    logic [2:0]          irq_match;
    logic                irq;
    logic [4:0]          res_bits;
    logic [19:0]         vel;
    logic [2:0][7:0]     req_edges;
    logic [7:0]          irq_edges;
    logic [31:0]         q;
    int                  num_errors;
    int                  checked;
    int                  cyc;
    logic [4:0]          res_tab [8] = '{5'h0D, 5'h0C, 5'h0B, 5'h0A, 5'h10, 5'h0E, 5'h0C, 5'h0C};
    logic [19:0]         vel_tab [8] = '{20'h1D4C0, 20'h3A980, 20'h75300, 20'hEA600,
                                         20'h03A98, 20'h0EA60, 20'h3A980, 20'h3A980};

    acmi_top i_acmi_top (.core_clk(core_clk), .srst(srst), .avs_req(req), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .phi_angle(phi_angle), .phi_valid(phi_valid),
        .phi_error(phi_error), .irq_match(irq_match), .irq(irq),
        .resolution_bits(res_bits), .max_velocity_rpm(vel));
    acmi_irq_sink i_acmi_irq_sink (.core_clk(core_clk), .srst(srst), .irq_match(irq_match),
        .irq(irq), .req_edges(req_edges), .irq_edges(irq_edges));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One Avalon cycle; the request holds until waitrequest is sampled low.
    task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
                        input logic [3:0] be);
        req.read       <= !wr;
        req.write      <= wr;
        req.address    <= a;
        req.writedata  <= d;
        req.byteenable <= be;
        do begin
            @(posedge core_clk);
        end while (wreq !== 1'b0);
        q = rdata;
        req.read  <= 1'b0;
        req.write <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic hit(input logic [15:0] a);
        phi_angle <= a;
        phi_valid <= 1'b1;
        @(posedge core_clk);
        phi_valid <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic t_reset();
        logic [5:0] ofs [8] = '{6'h0C, 6'h10, 6'h14, 6'h20, 6'h24, 6'h28, 6'h2C, 6'h30};
        foreach (ofs[i]) begin
            xfer(1'b0, ofs[i], 32'h0, 4'hF);
            `CHK(q, 32'h00000000)
        end
        `CHK(res_bits, 5'h0D)
        $display("t_reset done");
    endtask

    task automatic t_values();
        xfer(1'b1, `ACMI_OFS_CMP_A, 32'hA5A55A5A, 4'hF);
        xfer(1'b1, `ACMI_OFS_CMP_A, 32'h00003C00, 4'h2);
        xfer(1'b1, `ACMI_OFS_CMP_A, 32'hC3C30000, 4'hC);
        xfer(1'b0, `ACMI_OFS_CMP_A, 32'h0, 4'hF);
        `CHK(q, 32'hC3C33C5A)
        xfer(1'b1, `ACMI_OFS_CMP_B, 32'h0000BEEF, 4'h3);
        xfer(1'b0, `ACMI_OFS_CMP_B, 32'h0, 4'h1);
        `CHK(q[7:0], 8'hEF)
        xfer(1'b0, `ACMI_OFS_CMP_B, 32'h0, 4'hF);
        `CHK(q, 32'h0000BEEF)
        $display("t_values done");
    endtask

    task automatic t_velocity();
        for (int c = 0; c < 8; c++) begin
            xfer(1'b1, `ACMI_OFS_VSEL, {29'h0, 3'(c)}, 4'h1);
            `CHK(res_bits, res_tab[c])
            `CHK(vel, vel_tab[c])
        end
        $display("t_velocity done");
    endtask

    task automatic t_raw();
        xfer(1'b1, `ACMI_OFS_MASK, 32'h00000007, 4'h1);
        xfer(1'b0, `ACMI_OFS_MASK, 32'h0, 4'hF);
        `CHK(q, 32'h00000007)
        phi_angle <= 16'h3C5A;
        phi_valid <= 1'b1;
        @(posedge core_clk);
        phi_valid <= 1'b0;
        @(posedge core_clk);
        `CHK(irq_match, 3'h1)
        @(posedge core_clk);
        `CHK(irq_match, 3'h0)
        `CHK(irq, 1'b1)
        `CHK(req_edges[0], 8'h01)
        xfer(1'b0, `ACMI_OFS_CONTROL, 32'h0, 4'hF);
        `CHK(q, 32'h00000001)
        xfer(1'b0, `ACMI_OFS_STATUS, 32'h0, 4'hF);
        `CHK(q, 32'h00000001)
        `CHK(irq, 1'b0)
        xfer(1'b1, `ACMI_OFS_CONTROL, 32'h01000000, 4'h8);
        $display("t_raw done");
    endtask

    task automatic t_latched();
        xfer(1'b1, `ACMI_OFS_CONTROL, 32'h00010000, 4'h4);
        hit(16'hC3C3);
        repeat (3) @(posedge core_clk);
        `CHK(irq_match, 3'h2)
        xfer(1'b1, `ACMI_OFS_CONTROL, 32'h00000000, 4'h8);
        xfer(1'b0, `ACMI_OFS_CONTROL, 32'h0, 4'hF);
        `CHK(q, 32'h00010002)
        xfer(1'b1, `ACMI_OFS_CONTROL, 32'h02000000, 4'h8);
        xfer(1'b0, `ACMI_OFS_CONTROL, 32'h0, 4'hF);
        `CHK(q, 32'h00010000)
        `CHK(irq_match, 3'h0)
        `CHK(req_edges[1], 8'h01)
        xfer(1'b1, `ACMI_OFS_CONTROL, 32'h00000000, 4'h4);
        xfer(1'b0, `ACMI_OFS_STATUS, 32'h0, 4'hF);
        `CHK(q, 32'h00000002)
        $display("t_latched done");
    endtask

    task automatic t_lock();
        xfer(1'b1, `ACMI_OFS_ERRCTL, 32'h00000001, 4'h1);
        phi_error <= 1'b1;
        hit(16'hBEEF);
        xfer(1'b0, `ACMI_OFS_CONTROL, 32'h0, 4'hF);
        `CHK(q, 32'h00000000)
        phi_error <= 1'b0;
        hit(16'hBEEF);
        xfer(1'b0, `ACMI_OFS_CONTROL, 32'h0, 4'hF);
        `CHK(q, 32'h00000004)
        phi_error <= 1'b1;
        xfer(1'b1, `ACMI_OFS_CONTROL, 32'h04000000, 4'h8);
        xfer(1'b0, `ACMI_OFS_CONTROL, 32'h0, 4'hF);
        `CHK(q, 32'h00000000)
        phi_error <= 1'b0;
        xfer(1'b0, `ACMI_OFS_STATUS, 32'h0, 4'hF);
        `CHK(q, 32'h00000004)
        `CHK(irq_edges, 8'h03)
        $display("t_lock done");
    endtask

    initial begin
        num_errors = 0;
        checked    = 0;
        req        = '0;
        phi_angle  = 16'h0000;
        phi_valid  = 1'b0;
        phi_error  = 1'b0;
        srst       = 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_values();
        t_velocity();
        t_raw();
        t_latched();
        t_lock();
        stop_test();
    end
endmodule
